//--- bench/ext_irq_dev.sv
/*
 Model of the outside devices on the three active-low request lines.
 Assumes the lines idle high through a pull-up; a fire pulse pulls one low.
*/
`timescale 1ns/1ps
module ext_irq_dev (
  input wire logic clock_in,
  input wire logic [2:0] fire_in,
  output logic [2:0] lines_n_out
);
  logic [2:0] cnt_q [3];
  // Each line is held low four cycles so the falling edge is surely seen.
  always @(posedge clock_in)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (fire_in[i]) cnt_q[i] <= 3'h4;
      else if (cnt_q[i] != 3'h0) cnt_q[i] <= cnt_q[i] - 3'h1;
      lines_n_out[i] <= !(fire_in[i] || cnt_q[i] > 3'h1);
    end
  end
  initial
  begin
    lines_n_out = 3'h7;
    for (int i = 0; i < 3; i++) cnt_q[i] = 3'h0;
  end
endmodule

//--- bench/tb_top.sv
/*
 Self-checking bench for the interval timer and interrupt acceptance block.
 Assumes the design package and both timer rates; inputs move at falling edges.
*/
`timescale 1ns/1ps
module tb_top;
  logic clock_in = 1'b0, nrst_in = 1'b0, mem_wr_in = 1'b0, mem_rd_in = 1'b0;
  logic [15:0] mem_addr_in = 16'h0000, mem_wdata_in = 16'h0000, rx_data_in = 16'h0000;
  logic serial_rx_irq_in = 1'b0, serial_tx_irq_in = 1'b0, trap_in = 1'b0;
  logic irq_enable_in = 1'b1, busy_in = 1'b0, irq_ack_in = 1'b0;
  logic [2:0] fire = 3'h0, ext_irq_lines_n_in;
  logic [15:0] mem_rdata_out, tx_data_out, irq_vector_out, seed = 16'h003d, p, k;
  logic [7:0] global_alloc_out;
  logic mem_hit_out, irq_req_out, timer_irq_out, timer_irq_q;
  int n_mismatch = 0, comparisons = 0, n;
  always #25 clock_in = !clock_in;
  ext_irq_dev ext (.clock_in, .fire_in(fire), .lines_n_out(ext_irq_lines_n_in));
  interval_timer_irq_logic dut (.clock_in, .nrst_in, .mem_addr_in, .mem_wr_in, .mem_rd_in,
    .mem_wdata_in, .mem_rdata_out, .mem_hit_out, .ext_irq_lines_n_in, .serial_rx_irq_in,
    .serial_tx_irq_in, .rx_data_in, .tx_data_out, .global_alloc_out, .trap_in,
    .irq_enable_in, .busy_in, .irq_req_out, .irq_vector_out, .irq_ack_in, .timer_irq_out);
  // Quarter-rate twin shares every input; only its timer pulse is judged.
  interval_timer_irq_logic #(.QUARTER_RATE(1'b1)) dut_q (.clock_in, .nrst_in, .mem_addr_in,
    .mem_wr_in, .mem_rd_in, .mem_wdata_in, .mem_rdata_out(), .mem_hit_out(),
    .ext_irq_lines_n_in, .serial_rx_irq_in, .serial_tx_irq_in, .rx_data_in, .tx_data_out(),
    .global_alloc_out(), .trap_in, .irq_enable_in, .busy_in, .irq_req_out(),
    .irq_vector_out(), .irq_ack_in, .timer_irq_out(timer_irq_q));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] xs(input logic [15:0] s);
    s ^= s << 7;
    s ^= s >> 9;
    s ^= s << 8;
    return s;
  endfunction
  // Vectors sit two words apart; the trap takes the last slot.
  function automatic logic [15:0] exp_vec(input int s);
    return 16'(2 * (s + 1));
  endfunction
  function automatic int exp_gap(input logic [15:0] per, input bit q);
    return (int'(per) + 1) * (q ? 4 : 1);
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Strobes stay up across back-to-back calls; idle drops them.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    mem_addr_in = a; mem_wdata_in = d; mem_wr_in = 1'b1; mem_rd_in = 1'b0;
    @(negedge clock_in);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    mem_addr_in = a; mem_rd_in = 1'b1; mem_wr_in = 1'b0;
    @(negedge clock_in);
    check("rdata", mem_rdata_out, exp);
  endtask
  task automatic idle();
    mem_rd_in = 1'b0; mem_wr_in = 1'b0;
    @(negedge clock_in);
  endtask
  task automatic fire_src(input int s);
    if (s < 3) fire[s] = 1'b1;
    serial_rx_irq_in = (s == 4); serial_tx_irq_in = (s == 5); trap_in = (s == 6);
    @(negedge clock_in);
    fire = 3'h0; serial_rx_irq_in = 1'b0; serial_tx_irq_in = 1'b0; trap_in = 1'b0;
  endtask
  // Waits a bounded time for an offer, checks its vector, then acknowledges.
  task automatic take(input logic [15:0] exp);
    for (int i = 0; i < 20 && irq_req_out !== 1'b1; i++) @(negedge clock_in);
    check("vector", irq_req_out ? irq_vector_out : 16'hdead, exp);
    irq_ack_in = 1'b1;
    @(negedge clock_in);
    irq_ack_in = 1'b0;
    @(negedge clock_in);
  endtask
  task automatic gap(input bit q);
    for (int i = 0; i < 200 && (q ? timer_irq_q : timer_irq_out) !== 1'b1; i++)
      @(negedge clock_in);
    n = 0;
    do begin n++; @(negedge clock_in); end
    while (n < 200 && (q ? timer_irq_q : timer_irq_out) !== 1'b1);
    check(q ? "gap_quarter" : "gap", 16'(n), 16'(exp_gap(p, q)));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(negedge clock_in);
    nrst_in = 1'b1;
    rd(16'h0003, 16'hffff);
    rd(16'h0004, 16'h0000);
    rd(16'h0006, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed); rx_data_in = seed; wr(16'h0001, seed);
      rd(16'h0001, seed);
      rd(16'h0000, rx_data_in);
      wr(16'h0005, ~seed);
      rd(16'h0005, {8'h00, ~seed[7:0]});
    end
    seed = xs(seed); p = 16'h0002 + (seed & 16'h0007); k = 16'h0008 + (seed >> 10);
    wr(16'h0003, p); wr(16'h0002, k);
    rd(16'h0002, k);
    rd(16'h0002, k - 16'h0001);
    idle();
    gap(1'b0);
    gap(1'b1);
    // A long period keeps fresh timer events out of the acceptance scenarios below.
    wr(16'h0003, 16'hffff);
    wr(16'h0002, 16'hffff);
    for (int s = 0; s < 7; s++)
    begin
      wr(16'h0004, s < 6 ? 16'h0001 << s : 16'h0000); idle();
      if (s != 3) fire_src(s);
      take(exp_vec(s));
    end
    wr(16'h0004, 16'h0000); idle();
    fire_src(4);
    repeat (8) @(negedge clock_in);
    check("masked", 16'(irq_req_out), 16'h0000);
    // Global enable low must hold back an unmasked pending request as well.
    irq_enable_in = 1'b0;
    wr(16'h0004, 16'h0010);
    idle();
    repeat (8) @(negedge clock_in);
    check("disabled", 16'(irq_req_out), 16'h0000);
    irq_enable_in = 1'b1;
    busy_in = 1'b1; wr(16'h0004, 16'h0031); idle();
    fire_src(5); fire_src(0);
    repeat (8) @(negedge clock_in);
    check("busy", 16'(irq_req_out), 16'h0000);
    busy_in = 1'b0;
    take(exp_vec(0));
    take(exp_vec(4));
    take(exp_vec(5));
    end_of_test();
  end
  // Watchdog far beyond the few hundred cycles the sequence needs.
  initial
  begin
    repeat (20000) @(posedge clock_in);
    n_mismatch++;
    end_of_test();
  end
endmodule

//--- bench/timer_irq_properties.sv
/*
 Port-level checker for the interval timer and interrupt acceptance block.
 Assumes one clock and an asynchronous active-low reset, bound to the top.
*/
`timescale 1ns/1ps
module timer_irq_properties #(
  parameter bit QUARTER_RATE = 1'b0
)
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  input wire logic [15:0] mem_wdata_in,
  input wire logic [15:0] mem_rdata_out,
  input wire logic mem_hit_out,
  input wire logic [15:0] rx_data_in,
  input wire logic [15:0] tx_data_out,
  input wire logic [7:0] global_alloc_out,
  input wire logic irq_enable_in,
  input wire logic busy_in,
  input wire logic irq_req_out,
  input wire logic [15:0] irq_vector_out,
  input wire logic irq_ack_in,
  input wire logic timer_irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // Offer and vector stay put until the core acknowledges.
  property p_req_hold;
    irq_req_out && !irq_ack_in |=> irq_req_out && $stable(irq_vector_out);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("offer dropped early");
  property p_ack_drop;
    irq_req_out && irq_ack_in |=> !irq_req_out;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("offer kept after ack");
  property p_vec_align;
    irq_req_out |-> irq_vector_out[0] == 1'b0 && irq_vector_out[15:4] == 12'h000;
  endproperty
  a_vec_align: assert property (p_vec_align) else $error("vector off two-word grid");
  property p_busy;
    $rose(irq_req_out) |-> !$past(busy_in);
  endproperty
  a_busy: assert property (p_busy) else $error("offer during busy");
  property p_enable;
    $rose(irq_req_out) && irq_vector_out != 16'h000e |-> $past(irq_enable_in);
  endproperty
  a_enable: assert property (p_enable) else $error("maskable offer while disabled");
  property p_hit;
    mem_hit_out == (mem_addr_in < 16'h0006);
  endproperty
  a_hit: assert property (p_hit) else $error("decode hit wrong");
  property p_tx;
    mem_wr_in && mem_addr_in == 16'h0001 |=> tx_data_out == $past(mem_wdata_in);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit word not stored");
  property p_glob;
    mem_wr_in && mem_addr_in == 16'h0005 |=> global_alloc_out == $past(mem_wdata_in[7:0]);
  endproperty
  a_glob: assert property (p_glob) else $error("global value not stored");
  property p_rx;
    mem_rd_in && mem_addr_in == 16'h0000 |=> mem_rdata_out == $past(rx_data_in);
  endproperty
  a_rx: assert property (p_rx) else $error("receive word read wrong");
  property p_unmapped;
    mem_rd_in && mem_addr_in > 16'h0005 |=> mem_rdata_out == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_offer: cover property (irq_req_out && irq_ack_in);
  c_tick: cover property (timer_irq_out);
  c_busy: cover property (busy_in && !irq_req_out);
endmodule
bind interval_timer_irq_logic timer_irq_properties #(.QUARTER_RATE(QUARTER_RATE)) chk (
  .clock_in, .nrst_in, .mem_addr_in, .mem_wr_in, .mem_rd_in, .mem_wdata_in,
  .mem_rdata_out, .mem_hit_out, .rx_data_in, .tx_data_out, .global_alloc_out,
  .irq_enable_in, .busy_in, .irq_req_out, .irq_vector_out, .irq_ack_in, .timer_irq_out);

//--- logic/interval_timer.sv
/*
 Free-running 16-bit down counter with period reload and a zero pulse.
 Assumes write strobes are single-cycle pulses from the same clock domain.
*/
`timescale 1ns/1ps
module interval_timer #(
  parameter bit QUARTER_RATE = 1'b0
)
(
  input wire logic clock_in,
  input wire logic nrst_in,
  timer_link_if.tmr link
);

  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] period_q;
  logic [1:0] pre_q;
  logic irq_q;
  logic tick_w;
  logic at_zero_w;
  logic hit_w;

  ////////////////////////////////////////////////////////////////////////////
  // The prescaler always runs; it only matters in the quarter-rate variant.
  assign tick_w = QUARTER_RATE ? (pre_q == timer_irq_pkg::QUARTER_LAST) : 1'b1;
  assign at_zero_w = (count_q == 16'h0000);

  // A zero period keeps the count at zero, so every tick counts as a hit.
  assign hit_w = tick_w && !link.wr_count &&
                 ((count_q == 16'h0001) || (at_zero_w && period_q == 16'h0000));

  // A software load wins over the tick; zero reloads on the next tick.
  assign count_d = link.wr_count ? link.wdata :
                   !tick_w ? count_q :
                   at_zero_w ? period_q :
                   count_q - 16'h0001;

  // Counter, period store and prescaler.
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      count_q <= timer_irq_pkg::TIMER_RST;
      period_q <= timer_irq_pkg::PERIOD_RST;
      pre_q <= 2'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      pre_q <= pre_q + 2'h1;
      irq_q <= hit_w;
      if (link.wr_period)
      begin
        period_q <= link.wdata;
      end
    end
  end

  assign link.count = count_q;
  assign link.period = period_q;
  assign link.zero_irq = irq_q;

endmodule

//--- logic/interval_timer_irq_logic.sv
/*
 Mapped timer plus interrupt acceptance: six data-memory registers, three
 external active-low request lines, internal serial, timer and trap sources,
 fixed priority, two-word vectors and hold-off during multicycle work.
 Assumes the core drives single-cycle read and write strobes on the same
 clock, reports multicycle or wait-stated execution on busy_in, and answers
 each offered vector with a one-cycle irq_ack_in.
*/
// Operation
// - Timer is a 16-bit down counter decrementing every machine cycle, always on.
// - Variant option clocks the timer at one quarter of the machine rate.
// - Timer interrupt raised each time the count decrements to zero.
// - Count reloads from period one cycle after zero; period plus one cycles.
// - Three external maskable interrupt request lines are accepted.
// - Internal sources: serial receive, serial transmit, timer, software trap.
// - Fixed priority resolves collisions; reset highest, serial transmit lowest.
// - Every vector lies on a two-word boundary to hold a branch.
// - Servicing waits until a multicycle, repeated or wait-stated instruction ends.
// - Timer, period and mask are among six registers mapped in data memory.
`timescale 1ns/1ps
module interval_timer_irq_logic #(
  parameter bit QUARTER_RATE = 1'b0
)
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  input wire logic [15:0] mem_wdata_in,
  output logic [15:0] mem_rdata_out,
  output logic mem_hit_out,
  input wire logic [2:0] ext_irq_lines_n_in,
  input wire logic serial_rx_irq_in,
  input wire logic serial_tx_irq_in,
  input wire logic [15:0] rx_data_in,
  output logic [15:0] tx_data_out,
  output logic [7:0] global_alloc_out,
  input wire logic trap_in,
  input wire logic irq_enable_in,
  input wire logic busy_in,
  output logic irq_req_out,
  output logic [15:0] irq_vector_out,
  input wire logic irq_ack_in,
  output logic timer_irq_out
);

  timer_link_if link ();

  logic hit_rx_w;
  logic hit_tx_w;
  logic hit_timer_w;
  logic hit_period_w;
  logic hit_mask_w;
  logic hit_global_w;
  logic [15:0] read_mux_w;
  logic [15:0] rdata_q;
  logic [15:0] tx_data_q;
  logic [7:0] global_q;
  logic [5:0] irq_mask_reg_q;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] line_prev_q;
  logic [2:0] ext_edge_w;
  logic [5:0] set_w;
  logic [5:0] clr_w;
  logic [5:0] flags_q;
  logic [5:0] flags_d;
  logic [5:0] eligible_w;
  logic trap_q;
  logic trap_d;
  logic take_ack_w;
  logic pick_found;
  logic [2:0] pick_slot;
  logic start_w;
  logic [2:0] slot_q;
  logic [15:0] vector_q;
  logic [15:0] vector_d;
  timer_irq_pkg::accept_state_t state_q;
  timer_irq_pkg::accept_state_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode of the six mapped registers.
  assign hit_rx_w = (mem_addr_in == timer_irq_pkg::ADDR_RX_DATA);
  assign hit_tx_w = (mem_addr_in == timer_irq_pkg::ADDR_TX_DATA);
  assign hit_timer_w = (mem_addr_in == timer_irq_pkg::ADDR_TIMER);
  assign hit_period_w = (mem_addr_in == timer_irq_pkg::ADDR_PERIOD);
  assign hit_mask_w = (mem_addr_in == timer_irq_pkg::ADDR_MASK);
  assign hit_global_w = (mem_addr_in == timer_irq_pkg::ADDR_GLOBAL);
  assign mem_hit_out = hit_rx_w | hit_tx_w | hit_timer_w |
                       hit_period_w | hit_mask_w | hit_global_w;

  // Read selection; any other address reads as zero so the core can merge it.
  assign read_mux_w = hit_rx_w ? rx_data_in :
                      hit_tx_w ? tx_data_q :
                      hit_timer_w ? link.count :
                      hit_period_w ? link.period :
                      hit_mask_w ? {10'h000, irq_mask_reg_q} :
                      hit_global_w ? {8'h00, global_q} :
                      16'h0000;

  // Timer writes go straight to the counter or period store.
  assign link.wr_count = mem_wr_in & hit_timer_w;
  assign link.wr_period = mem_wr_in & hit_period_w;
  assign link.wdata = mem_wdata_in;

  ////////////////////////////////////////////////////////////////////////////
  // Timer instance.
  interval_timer #(
    .QUARTER_RATE(QUARTER_RATE)
  ) u_timer (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .link(link)
  );

  assign timer_irq_out = link.zero_irq;

  // Register stores; read data is captured so it stands until the next read.
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rdata_q <= 16'h0000;
      tx_data_q <= timer_irq_pkg::TX_DATA_RST;
      global_q <= timer_irq_pkg::GLOBAL_RST;
      irq_mask_reg_q <= timer_irq_pkg::MASK_RST;
    end
    else
    begin
      if (mem_rd_in)
      begin
        rdata_q <= read_mux_w;
      end
      if (mem_wr_in && hit_tx_w)
      begin
        tx_data_q <= mem_wdata_in;
      end
      if (mem_wr_in && hit_global_w)
      begin
        global_q <= mem_wdata_in[7:0];
      end
      if (mem_wr_in && hit_mask_w)
      begin
        irq_mask_reg_q <= mem_wdata_in[5:0];
      end
    end
  end

  assign mem_rdata_out = rdata_q;
  assign tx_data_out = tx_data_q;
  assign global_alloc_out = global_q;

  ////////////////////////////////////////////////////////////////////////////
  // External lines are asynchronous; two flops first, then a falling edge
  // seen on the settled copy latches a request.
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      line_prev_q <= 3'h7;
    end
    else
    begin
      sync1_q <= ext_irq_lines_n_in;
      sync2_q <= sync1_q;
      line_prev_q <= sync2_q;
    end
  end

  assign ext_edge_w = line_prev_q & ~sync2_q;

  // Source collection in priority order, external lines first.
  assign set_w[timer_irq_pkg::SRC_EXT0] = ext_edge_w[0];
  assign set_w[timer_irq_pkg::SRC_EXT1] = ext_edge_w[1];
  assign set_w[timer_irq_pkg::SRC_EXT2] = ext_edge_w[2];
  assign set_w[timer_irq_pkg::SRC_TIMER] = link.zero_irq;
  assign set_w[timer_irq_pkg::SRC_RX] = serial_rx_irq_in;
  assign set_w[timer_irq_pkg::SRC_TX] = serial_tx_irq_in;

  assign take_ack_w = (state_q == timer_irq_pkg::ST_OFFER) && irq_ack_in;

  // A new event in the cycle its flag is cleared keeps the flag set.
  generate
    for (genvar g = 0; g < timer_irq_pkg::NUM_SRC; g++)
    begin : g_flag
      assign clr_w[g] = take_ack_w && (slot_q == 3'(g + 1));
      assign flags_d[g] = set_w[g] | (flags_q[g] & ~clr_w[g]);
    end
  endgenerate

  // The trap is an instruction, so it ignores the mask and global enable.
  assign trap_d = trap_in |
                  (trap_q & ~(take_ack_w && slot_q == timer_irq_pkg::SLOT_TRAP));

  // Unmasked requests stay pending in their flags until serviced.
  assign eligible_w = flags_q & irq_mask_reg_q & {6{irq_enable_in}};

  ////////////////////////////////////////////////////////////////////////////
  // Fixed priority pick: trap, then the lowest set source bit.
  always_comb
  begin
    pick_found = 1'b0;
    pick_slot = timer_irq_pkg::SLOT_RESET;
    for (int i = timer_irq_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (eligible_w[i])
      begin
        pick_found = 1'b1;
        pick_slot = 3'(i + 1);
      end
    end
    if (trap_q)
    begin
      pick_found = 1'b1;
      pick_slot = timer_irq_pkg::SLOT_TRAP;
    end
  end

  // Nothing is offered while the current instruction is still running.
  assign start_w = pick_found && !busy_in;
  assign vector_d = timer_irq_pkg::VEC_BASE +
                    timer_irq_pkg::VEC_STEP * {13'h0000, pick_slot};

  // Offer handshake: the pick is frozen until the core acknowledges.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      timer_irq_pkg::ST_IDLE:
      begin
        if (start_w)
        begin
          state_d = timer_irq_pkg::ST_OFFER;
        end
      end
      timer_irq_pkg::ST_OFFER:
      begin
        if (irq_ack_in)
        begin
          state_d = timer_irq_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Reset clears every pending request and points the vector at slot zero.
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_q <= timer_irq_pkg::ST_IDLE;
      flags_q <= 6'h00;
      trap_q <= 1'b0;
      slot_q <= timer_irq_pkg::SLOT_RESET;
      vector_q <= timer_irq_pkg::VEC_BASE;
    end
    else
    begin
      state_q <= state_d;
      flags_q <= flags_d;
      trap_q <= trap_d;
      if (state_q == timer_irq_pkg::ST_IDLE && start_w)
      begin
        slot_q <= pick_slot;
        vector_q <= vector_d;
      end
    end
  end

  assign irq_req_out = (state_q == timer_irq_pkg::ST_OFFER);
  assign irq_vector_out = vector_q;

endmodule

//--- logic/timer_irq_pkg.sv
/*
 Shared constants for the interval timer and interrupt acceptance block:
 mapped register addresses, reset values, source bit positions and vectors.
 Assumes a 16-bit word-addressed data memory path from the core.
*/
package timer_irq_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_EXT = 3;
  localparam int unsigned NUM_SRC = 6;

  // Word addresses of the six mapped registers in data memory space.
  localparam logic [15:0] ADDR_RX_DATA = 16'h0000;
  localparam logic [15:0] ADDR_TX_DATA = 16'h0001;
  localparam logic [15:0] ADDR_TIMER = 16'h0002;
  localparam logic [15:0] ADDR_PERIOD = 16'h0003;
  localparam logic [15:0] ADDR_MASK = 16'h0004;
  localparam logic [15:0] ADDR_GLOBAL = 16'h0005;

  // Reset values.
  localparam logic [15:0] TIMER_RST = 16'hffff;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [15:0] TX_DATA_RST = 16'h0000;
  localparam logic [7:0] GLOBAL_RST = 8'h00;

  // Bit positions of the maskable sources, highest priority at bit 0.
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_EXT1 = 1;
  localparam int unsigned SRC_EXT2 = 2;
  localparam int unsigned SRC_TIMER = 3;
  localparam int unsigned SRC_RX = 4;
  localparam int unsigned SRC_TX = 5;

  // Vector slots: slot 0 is reset, maskable source n is slot n+1.
  localparam logic [2:0] SLOT_RESET = 3'h0;
  localparam logic [2:0] SLOT_TRAP = 3'h7;
  localparam logic [15:0] VEC_BASE = 16'h0000;
  localparam logic [15:0] VEC_STEP = 16'h0002;

  // Prescaler terminal value for the quarter-rate timer variant.
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_OFFER
  } accept_state_t;

endpackage

//--- logic/timer_link_if.sv
/*
 Link between the register decode of the top module and the timer.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface timer_link_if;
  logic wr_count;
  logic wr_period;
  logic [15:0] wdata;
  logic [15:0] count;
  logic [15:0] period;
  logic zero_irq;

  modport ctl (output wr_count, output wr_period, output wdata,
               input count, input period, input zero_irq);
  modport tmr (input wr_count, input wr_period, input wdata,
               output count, output period, output zero_irq);
endinterface
